// ---- verilog/host_port_pkg.sv ----
// shared constants and types for the strobe/acknowledge host port
// assumes one master clock; all latencies are counted in its cycles
`default_nettype none
package host_port_pkg;

  // bus and counter widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int CNT_W  = 8;

  // acknowledge latencies in master clock cycles, measured from the
  // first edge that sees chip select and data strobe both active
  localparam logic [CNT_W-1:0] REG_RD_LAT = 8'h0e; // inside 13..16 exclusive
  localparam logic [CNT_W-1:0] REG_WR_LAT = 8'h0c; // inside 11..14 exclusive
  localparam logic [CNT_W-1:0] MEM_RD_MIN = 8'h0e; // least memory read latency
  localparam logic [CNT_W-1:0] MEM_WR_MIN = 8'h0c; // least memory write latency
  localparam logic [CNT_W-1:0] ACK_MAX    = 8'h85; // longest latency, 133 cycles
  // lead of read data over the acknowledge
  localparam logic [CNT_W-1:0] DATA_LEAD  = 8'h01;
  // the timeout acknowledges one cycle early to absorb strobe sampling skew
  localparam logic [CNT_W-1:0] MAX_GUARD  = 8'h02;

  // access sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REG  = 3'b001,
    ST_MEM  = 3'b010,
    ST_HOLD = 3'b011,
    ST_GAP  = 3'b100
  } port_state_t;

endpackage
`default_nettype wire

// ---- verilog/ack_timer_if.sv ----
// signals between the access sequencer and its latency timer
// assumes both ends share the master clock
`timescale 1ns/1ps
`default_nettype none
interface ack_timer_if;
  import host_port_pkg::*;

  logic             run;     // access in progress
  logic             done;    // target has answered
  logic [CNT_W-1:0] target;  // latency for this access
  logic             present; // data goes out next edge, acknowledge the edge after
  logic [CNT_W-1:0] count;   // cycles since the access was taken

  modport ctrl  (output run, done, target, input present, count);
  modport timer (input run, done, target, output present, count);
endinterface
`default_nettype wire

// ---- verilog/ack_timer.sv ----
// latency timer for the host port acknowledge
// assumes run rises on the same edge that takes an access
`timescale 1ns/1ps
`default_nettype none
module ack_timer (
  // clock and reset
  input  wire logic  clk_in,
  input  wire logic  rst_in,
  // sequencer side
  ack_timer_if.timer tif
);
  import host_port_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             pre;
  } timer_regs_t;

  timer_regs_t st_ff;
  timer_regs_t nxt_st;

  // count up while running; flag two cycles before the acknowledge
  always_comb begin
    nxt_st = st_ff;
    if (!tif.run) begin
      nxt_st.cnt = '0;
      nxt_st.pre = 1'b0;
    end else begin
      if (st_ff.cnt != ACK_MAX) begin
        nxt_st.cnt = st_ff.cnt + 8'h01;
      end
      // data one cycle ahead
      // the flag and the sequencer register each cost an edge, hence one more
      if (tif.done && nxt_st.cnt >= (tif.target - DATA_LEAD - 8'h01)) begin
        nxt_st.pre = 1'b1;
      end
      if (nxt_st.cnt >= (ACK_MAX - MAX_GUARD - 8'h01)) begin
        nxt_st.pre = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tif.present = st_ff.pre;
  assign tif.count   = st_ff.cnt;
endmodule
`default_nettype wire

// ---- verilog/strobe_host_port.sv ----
// strobe and acknowledge host port: decodes host accesses and answers each one
// not abandoned by a rising strobe with an acknowledge at a fixed or bounded master clock latency.
// assumes host pins are synchronous to clk_in; the wired acknowledge
// and data bus levels are resolved outside from the enables.
`timescale 1ns/1ps
`default_nettype none
module strobe_host_port #(
  parameter int AW = host_port_pkg::ADDR_W,
  parameter int DW = host_port_pkg::DATA_W
) (
  // clock and reset
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  // host bus controls
  input  wire logic          cs_n_in,
  input  wire logic          data_strobe_n_in,
  input  wire logic          rw_in,            // high reads, low writes
  input  wire logic          addr_space_ext_in,
  input  wire logic [AW-1:0] addr_in,
  // host data bus, two-way
  input  wire logic [DW-1:0] data_in,
  output logic      [DW-1:0] data_out,
  output logic               data_oe_out,
  // acknowledge, shared line
  output logic               transfer_ack_n_out,
  output logic               transfer_ack_oe_out,
  // internal register file
  output logic               reg_req_out,
  output logic               reg_we_out,
  output logic      [AW-1:0] reg_addr_out,
  output logic      [DW-1:0] reg_wdata_out,
  input  wire logic [DW-1:0] reg_rdata_in,
  // external memory controller
  output logic               mem_req_out,
  output logic               mem_we_out,
  output logic      [AW-1:0] mem_addr_out,
  output logic      [DW-1:0] mem_wdata_out,
  input  wire logic          mem_ack_in,
  input  wire logic [DW-1:0] mem_rdata_in
);
  import host_port_pkg::*;

  // all sequencer state in one register; ack and ack_oe are kept apart so
  // the line can be driven high long before completion is signalled
  typedef struct packed {
    port_state_t   state;
    logic          is_read;
    logic          ack;     // acknowledge asserted (line low)
    logic          ack_oe;  // acknowledge line driven
    logic          data_oe; // read data on the bus
    logic          done;    // target answered
    logic          reg_req;
    logic          mem_req;
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
  } port_regs_t;

  port_regs_t st_ff;
  port_regs_t nxt_st;

  // the timer sits apart so its counter can saturate without touching the
  // sequencer; it only ever sees run, done and the target latency
  ack_timer_if tif ();

  // address space decode, used only when an access is taken
  // kept as a function so a wider decode later changes one place only
  function automatic logic is_mem_space(input logic ext);
    return ext;
  endfunction

  // latency for the access kind
  function automatic logic [CNT_W-1:0] lat_of(input logic rd, input logic mem);
    if (mem) begin
      return rd ? MEM_RD_MIN : MEM_WR_MIN;
    end
    return rd ? REG_RD_LAT : REG_WR_LAT;
  endfunction

  // raw pin terms; pins are taken as synchronous, so no extra stage
  logic both_active;
  logic strobe_lost;

  assign both_active = !cs_n_in && !data_strobe_n_in;
  assign strobe_lost = cs_n_in || data_strobe_n_in;

  // sequencer next state
  // the host sees the acknowledge up to a cycle later than the edge count
  // because the strobes are sampled, so latencies sit inside each window
  always_comb begin
    nxt_st = st_ff;
    nxt_st.reg_req = 1'b0;
    // drive the line only while selected
    nxt_st.ack_oe = !cs_n_in;
    case (st_ff.state)
      ST_IDLE: begin
        // take the access on both strobes
        if (both_active) begin
          nxt_st.is_read = rw_in;
          nxt_st.we      = !rw_in;
          nxt_st.addr    = addr_in;
          nxt_st.wdata   = data_in;
          nxt_st.done    = 1'b0;
          if (is_mem_space(addr_space_ext_in)) begin
            nxt_st.state   = ST_MEM;
            nxt_st.mem_req = 1'b1;
          end else begin
            nxt_st.state   = ST_REG;
            nxt_st.reg_req = 1'b1;
          end
        end
      end
      ST_REG, ST_MEM: begin
        // abandon wins over a same-edge answer so no acknowledge follows
        if (strobe_lost) begin
          nxt_st.state   = ST_GAP;
          nxt_st.mem_req = 1'b0;
        end else begin
          // register data is taken in the same cycle as the request pulse
          if (st_ff.state == ST_REG && st_ff.reg_req) begin
            nxt_st.rdata = reg_rdata_in;
            nxt_st.done  = 1'b1;
          end
          // memory request is a level held until the controller answers
          if (st_ff.state == ST_MEM && st_ff.mem_req && mem_ack_in) begin
            nxt_st.mem_req = 1'b0;
            nxt_st.rdata   = mem_rdata_in;
            nxt_st.done    = 1'b1;
          end
          // data out one cycle before the acknowledge
          if (tif.present) begin
            nxt_st.data_oe = st_ff.is_read;
            nxt_st.state   = ST_HOLD;
            nxt_st.mem_req = 1'b0; // a timed out memory access is dropped
          end
        end
      end
      ST_HOLD: begin
        // acknowledge one edge after the data lead
        nxt_st.ack = 1'b1;
        if (strobe_lost) begin
          // data held until a strobe rises
          nxt_st.ack     = 1'b0;
          nxt_st.data_oe = 1'b0;
          nxt_st.state   = ST_GAP;
        end
      end
      ST_GAP: begin
        // a new access needs chip select to have gone high
        // a strobe pulse under a held chip select is ignored here on purpose
        nxt_st.ack     = 1'b0;
        nxt_st.data_oe = 1'b0;
        if (cs_n_in) begin
          nxt_st.state = ST_IDLE;
        end
      end
      default: begin
        nxt_st = '0;
      end
    endcase
  end

  // single state register
  // synchronous reset clears every field; the acknowledge then reads high
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // timer runs only while an access sits in ST_REG or ST_MEM, until its data lead
  // the target follows the captured direction and space, so a host that
  // moves rw_in mid access cannot move the acknowledge
  assign tif.run    = (st_ff.state == ST_REG) || (st_ff.state == ST_MEM);
  assign tif.done   = st_ff.done;
  assign tif.target = lat_of(st_ff.is_read, st_ff.state == ST_MEM);

  // latency timer
  ack_timer ack_timer_i (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .tif    (tif.timer)
  );

  // host side outputs, all from flip-flops
  // line drivers outside use the enables; a released line floats to the
  // pull-up, which the host reads as not yet acknowledged
  assign data_out            = st_ff.rdata;
  assign data_oe_out         = st_ff.data_oe;
  // high while driven and not yet complete
  assign transfer_ack_n_out  = !st_ff.ack;
  assign transfer_ack_oe_out = st_ff.ack_oe;

  // register file side
  assign reg_req_out   = st_ff.reg_req;
  assign reg_we_out    = st_ff.we;
  assign reg_addr_out  = st_ff.addr;
  assign reg_wdata_out = st_ff.wdata;

  // memory side
  // a memory request that times out is dropped; stale read data is still
  // presented, the price of a bounded acknowledge
  assign mem_req_out   = st_ff.mem_req;
  assign mem_we_out    = st_ff.we;
  assign mem_addr_out  = st_ff.addr;
  assign mem_wdata_out = st_ff.wdata;
endmodule
`default_nettype wire

// ---- verif/strobe_host_port_checker.sv ----
// assertion checker for the strobe host port, bound to its top module
// assumes the host keeps chip select high for three cycles between accesses
`timescale 1ns/1ps
`default_nettype none
module strobe_host_port_checker (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // host side
  input wire logic cs_n_in,
  input wire logic data_strobe_n_in,
  input wire logic rw_in,
  input wire logic addr_space_ext_in,
  input wire logic data_oe_out,
  input wire logic transfer_ack_n_out,
  input wire logic transfer_ack_oe_out
);
  logic       idle_ff;
  logic [7:0] cnt_ff;
  wire        both = !cs_n_in && !data_strobe_n_in;

  // cycles since the strobes met; saturates so a stuck access stays visible
  always_ff @(posedge clk_in) begin
    idle_ff <= rst_in || !both;
    if (rst_in)
      cnt_ff <= 8'h00;
    else if (both && idle_ff)
      cnt_ff <= 8'h01;
    else if (cnt_ff != 8'hff)
      cnt_ff <= cnt_ff + 8'h01;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence ack_fall;
    $fell(transfer_ack_n_out);
  endsequence

  a_reg_rd_lat: assert property (ack_fall ##0 (rw_in && !addr_space_ext_in) |-> cnt_ff == 8'h0f)
    else $error("register read acknowledge off time");
  a_reg_wr_lat: assert property (ack_fall ##0 (!rw_in && !addr_space_ext_in) |-> cnt_ff == 8'h0d)
    else $error("register write acknowledge off time");
  a_mem_rd_lat: assert property (ack_fall ##0 (rw_in && addr_space_ext_in) |-> cnt_ff inside {[8'h0f:8'h85]})
    else $error("memory read acknowledge off time");
  a_mem_wr_lat: assert property (ack_fall ##0 (!rw_in && addr_space_ext_in) |-> cnt_ff inside {[8'h0d:8'h85]})
    else $error("memory write acknowledge off time");
  a_ack_not_late: assert property (both && !idle_ff && transfer_ack_n_out |-> cnt_ff < 8'h85)
    else $error("acknowledge later than allowed");
  a_ack_drive: assert property (transfer_ack_oe_out == !$past(cs_n_in))
    else $error("acknowledge drive does not follow chip select");
  a_end_release: assert property (!transfer_ack_n_out && !both |=> transfer_ack_n_out && !data_oe_out)
    else $error("access not ended by strobe");
  a_data_lead: assert property (ack_fall ##0 rw_in |-> $past(data_oe_out) && !$past(data_oe_out, 2))
    else $error("read data not one cycle ahead");
endmodule

bind strobe_host_port strobe_host_port_checker chk_i (.clk_in, .rst_in, .cs_n_in, .data_strobe_n_in, .rw_in,
  .addr_space_ext_in, .data_oe_out, .transfer_ack_n_out, .transfer_ack_oe_out);
`default_nettype wire

// ---- verif/far_store_model.sv ----
// responder for the register file and memory behind the host port
// assumes stimulus on falling edges; the bench sets the wait per access
`timescale 1ns/1ps
`default_nettype none
module far_store_model (
  // clock
  input  wire logic        clk_in,
  // memory controller side
  input  wire logic        mem_req_in,
  input  wire logic [19:0] mem_addr_in,
  input  wire logic [7:0]  wait_in,
  output logic             mem_ack_out,
  output logic [15:0]      mem_rdata_out,
  // register file side
  input  wire logic [19:0] reg_addr_in,
  output logic [15:0]      reg_rdata_out
);
  logic [7:0] w;

  initial mem_ack_out = 1'b0;
  initial w = 8'h00;
  // data outside the answer cycle is inverted, so a late sample shows
  assign mem_rdata_out = (mem_addr_in[15:0] ^ 16'h3c5a) ^ {16{!mem_ack_out}};
  assign reg_rdata_out = reg_addr_in[15:0] ^ 16'ha5c3;
  // one-cycle answer after wait_in cycles of request
  always @(negedge clk_in) begin
    mem_ack_out <= mem_req_in && !mem_ack_out && w == wait_in;
    w <= (mem_req_in && !mem_ack_out) ? w + 8'h01 : 8'h00;
  end
endmodule
`default_nettype wire

// ---- verif/test_strobe_host_port.sv ----
// self-checking bench for the strobe host port
// assumes a pulled-up acknowledge line and the responder model
`timescale 1ns/1ps
`default_nettype none
module test_strobe_host_port;
  import host_port_pkg::*;
  logic        clk_in, rst_in, cs_n, ds_n, rw, ext, r_we, m_we, data_oe, ack_n, ack_oe, r_req, m_req, m_ack;
  logic [19:0] addr, r_ad, m_ad;
  logic [15:0] wdata, data_out, r_wd, m_wd, r_rd, m_rd;
  logic [7:0]  wait_c;
  logic [31:0] rnd;
  wire         ack_line = ack_oe ? ack_n : 1'b1; // pull-up when released
  int          mismatches = 0, num_checks = 0, cyc = 0, n;

  strobe_host_port strobe_host_port_i (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n),
    .data_strobe_n_in(ds_n), .rw_in(rw), .addr_space_ext_in(ext), .addr_in(addr), .data_in(wdata),
    .data_out(data_out), .data_oe_out(data_oe), .transfer_ack_n_out(ack_n), .transfer_ack_oe_out(ack_oe),
    .reg_req_out(r_req), .reg_we_out(r_we), .reg_addr_out(r_ad), .reg_wdata_out(r_wd), .reg_rdata_in(r_rd),
    .mem_req_out(m_req), .mem_we_out(m_we), .mem_addr_out(m_ad), .mem_wdata_out(m_wd), .mem_ack_in(m_ack),
    .mem_rdata_in(m_rd));
  far_store_model far_store_model_i (.clk_in(clk_in), .mem_req_in(m_req), .mem_addr_in(m_ad),
    .wait_in(wait_c), .mem_ack_out(m_ack), .mem_rdata_out(m_rd), .reg_addr_in(r_ad), .reg_rdata_out(r_rd));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic give_verdict();
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  function automatic logic [15:0] exp_rd(input logic e, input logic [19:0] a);
    return a[15:0] ^ (e ? 16'h3c5a : 16'ha5c3);
  endfunction

  // half-cycle count from strobe fall to ack seen, against the open range
  function automatic logic lat_ok(input logic r, input logic e, input int c);
    int lo = (r ? 13 : 11) + (e ? 1 : 0);
    int hi = e ? 133 : (r ? 16 : 14);
    return (2 * c - 1 > 2 * lo) && (2 * c - 1 < 2 * hi);
  endfunction

  // one host access; address and direction stay put until the strobes rise
  task automatic acc(input logic r, input logic e, input logic [19:0] a, input logic [15:0] d,
                     input logic [7:0] w);
    @(negedge clk_in);
    rw = r;
    ext = e;
    addr = a;
    wdata = d;
    wait_c = w;
    n = 0;
    cs_n = 1'b0;
    ds_n = 1'b0;
    while (ack_line === 1'b1 && n < 200) begin
      @(negedge clk_in);
      n++;
      if (r_req) chk(!e && r_we === !r && r_ad === a && (r || r_wd === d), "register request");
      if (m_req) chk(e && m_we === !r && m_ad === a && (r || m_wd === d), "memory request");
    end
    chk(lat_ok(r, e, n), "acknowledge latency");
    if (r && !(e && w > 8'h78)) chk(data_oe === 1'b1 && data_out === exp_rd(e, a), "read data");
    cs_n = 1'b1;
    ds_n = 1'b1;
    repeat (3) @(negedge clk_in);
  endtask

  // hang guard, far above the expected run length
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    {cs_n, ds_n, rw, ext, addr, wdata, wait_c, rst_in} = {4'hc, 20'h00000, 16'h0000, 8'h00, 1'b1};
    rnd = $urandom(32'hd60870a5);
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    for (int i = 0; i < 4; i++) acc(i[0], i[1], 20'hfffff, 16'hffff, 8'h00);
    acc(1'b1, 1'b1, 20'h00000, 16'h0000, 8'h8c);
    acc(1'b0, 1'b1, 20'h00001, 16'h8000, 8'h8c);
    // strobe without chip select must start nothing
    ds_n = 1'b0;
    repeat (8) @(negedge clk_in);
    chk(!r_req && !m_req && !ack_oe, "access without chip select");
    ds_n = 1'b1;
    // strobe raised before the answer abandons a slow memory read
    @(negedge clk_in);
    {rw, ext, wait_c, cs_n, ds_n} = {2'b11, 8'h64, 2'b00};
    repeat (20) @(negedge clk_in);
    ds_n = 1'b1;
    repeat (3) @(negedge clk_in);
    chk(ack_line === 1'b1 && m_req === 1'b0 && ack_oe === 1'b1, "abandoned access");
    cs_n = 1'b1;
    repeat (2) @(negedge clk_in);
    chk(ack_oe === 1'b0, "acknowledge not released");
    for (int i = 0; i < 40; i++) begin
      rnd = $urandom;
      acc(rnd[0], rnd[1], 20'($urandom), 16'($urandom), 8'($urandom_range(60)));
    end
    give_verdict();
  end
endmodule
`default_nettype wire
